// ===== rtl/mcr_pkg.sv
// Package for the motor command output router
`default_nettype none
package mcr_pkg;
    localparam int          NUM_MOTORS          = 8;
    localparam int          ADDR_W              = 16;
    localparam int          DATA_W              = 24;
    // Output address setting fields
    localparam int          OUT_SPACE_BIT       = 19;
    localparam int          OUT_SIGNMAG_BIT     = 16;
    // Flag register fields
    localparam int          FLAG_SIGN_BIT       = 14;
    // Bus register offsets, per-motor stride 0x20
    localparam logic [11:0] REG_CTRL            = 12'h000;
    localparam logic [11:0] REG_OUT_ADDR        = 12'h004;
    localparam logic [11:0] REG_FLAG_ADDR       = 12'h008;
    localparam logic [11:0] REG_CMD             = 12'h00c;
    localparam logic [11:0] REG_CMD_B           = 12'h010;
    localparam logic [11:0] REG_CMD_C           = 12'h014;
    localparam logic [11:0] REG_STATUS          = 12'h018;
    localparam logic [11:0] REG_GLOBAL          = 12'h100;
    localparam int          MOTOR_STRIDE_SHIFT  = 5;
    // Reset values
    localparam logic [31:0] CTRL_RESET          = 32'h0000_0000;
    localparam logic [23:0] OUT_ADDR_RESET      = 24'h00c002;
    localparam logic [23:0] FLAG_ADDR_RESET     = 24'h00c000;
    // Servo cycle period in clock cycles (default)
    localparam int          SERVO_PERIOD        = 4096;
    typedef enum logic [1:0] {
        MCR_ONE,
        MCR_TWO,
        MCR_THREE
    } mcr_count_type;
endpackage
`default_nettype wire

// ===== rtl/mcr_router.sv
// Motor command output router with AHB-Lite register access
`timescale 1ns/1ps
`default_nettype none
module mcr_router #(
    parameter int SERVO_PERIOD = mcr_pkg::SERVO_PERIOD,
    parameter int NUM_MOTORS   = mcr_pkg::NUM_MOTORS
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [23:0] feedback_delta,
    output logic             out_we,
    output logic             out_space_x,
    output logic      [15:0] out_addr,
    output logic      [23:0] out_data,
    output logic             flag_we,
    output logic      [15:0] flag_addr,
    output logic             flag_sign,
    output logic             servo_tick
);
    localparam int MW = $clog2(NUM_MOTORS);
    localparam int CW = $clog2(SERVO_PERIOD);

    // Per-motor configuration and state
    logic             motor_activate       [NUM_MOTORS];
    logic             commutation_enable   [NUM_MOTORS];
    logic [7:0]       current_loop_setting [NUM_MOTORS];
    logic [23:0]      command_output_address [NUM_MOTORS];
    logic [23:0]      flag_register_address  [NUM_MOTORS];
    logic [23:0]      cmd_val [NUM_MOTORS][3];
    logic [23:0]      position [NUM_MOTORS];
    logic [15:0]      write_count [NUM_MOTORS];
    logic             variant_two;

    // Bus address phase capture
    logic        ph_valid;
    logic        ph_write;
    logic [11:0] ph_addr;

    function automatic logic [1:0] out_count(input logic comm,
                                             input logic [7:0] cl);
        if (!comm)
            out_count = 2'd1;
        else if (cl == 8'h00)
            out_count = 2'd2;
        else
            out_count = 2'd3;
    endfunction

    // Bus slave: zero wait, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid  <= 1'b0;
            ph_write  <= 1'b0;
            ph_addr   <= 12'h000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            if (hready) begin
                ph_valid <= hsel & htrans[1];
                ph_write <= hwrite;
                ph_addr  <= haddr[11:0];
            end
        end
    end

    logic [MW-1:0] ph_motor;
    logic [4:0]    ph_off;
    logic          ph_global;
    always_comb begin
        ph_motor  = ph_addr[MW+4:5];
        ph_off    = ph_addr[4:0];
        ph_global = ph_addr == mcr_pkg::REG_GLOBAL;
    end

    // Read data, combinational from registered state
    always_comb begin
        hrdata = 32'h0000_0000;
        if (ph_valid && !ph_write) begin
            if (ph_global)
                hrdata = {31'h0, variant_two};
            else if (ph_addr[11:8] == 4'h0) begin
                unique case ({7'h00, ph_off})
                    mcr_pkg::REG_CTRL:
                        hrdata = {22'h0, current_loop_setting[ph_motor],
                                  commutation_enable[ph_motor],
                                  motor_activate[ph_motor]};
                    mcr_pkg::REG_OUT_ADDR:
                        hrdata = {8'h0, command_output_address[ph_motor]};
                    mcr_pkg::REG_FLAG_ADDR:
                        hrdata = {8'h0, flag_register_address[ph_motor]};
                    mcr_pkg::REG_CMD:   hrdata = {8'h0, cmd_val[ph_motor][0]};
                    mcr_pkg::REG_CMD_B: hrdata = {8'h0, cmd_val[ph_motor][1]};
                    mcr_pkg::REG_CMD_C: hrdata = {8'h0, cmd_val[ph_motor][2]};
                    mcr_pkg::REG_STATUS:
                        hrdata = {write_count[ph_motor],
                                  position[ph_motor][15:0]};
                    default: hrdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // Register writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            variant_two <= 1'b0;
            for (int m = 0; m < NUM_MOTORS; m++) begin
                motor_activate[m]         <= (m == 0);
                commutation_enable[m]     <= 1'b0;
                current_loop_setting[m]   <= 8'h00;
                command_output_address[m] <= mcr_pkg::OUT_ADDR_RESET;
                flag_register_address[m]  <= mcr_pkg::FLAG_ADDR_RESET;
                for (int k = 0; k < 3; k++)
                    cmd_val[m][k] <= 24'h000000;
            end
        end else if (ph_valid && ph_write) begin
            if (ph_global)
                variant_two <= hwdata[0];
            else if (ph_addr[11:8] == 4'h0) begin
                unique case ({7'h00, ph_off})
                    mcr_pkg::REG_CTRL: begin
                        motor_activate[ph_motor]       <= hwdata[0];
                        commutation_enable[ph_motor]   <= hwdata[1];
                        current_loop_setting[ph_motor] <= hwdata[9:2];
                    end
                    mcr_pkg::REG_OUT_ADDR:
                        command_output_address[ph_motor] <= hwdata[23:0];
                    mcr_pkg::REG_FLAG_ADDR:
                        flag_register_address[ph_motor] <= hwdata[23:0];
                    mcr_pkg::REG_CMD:   cmd_val[ph_motor][0] <= hwdata[23:0];
                    mcr_pkg::REG_CMD_B: cmd_val[ph_motor][1] <= hwdata[23:0];
                    mcr_pkg::REG_CMD_C: cmd_val[ph_motor][2] <= hwdata[23:0];
                    default: ;
                endcase
            end
        end
    end

    // Servo cycle sequencer
    logic [CW-1:0] tick_cnt;
    logic [CW-1:0] next_tick_cnt;
    logic [MW-1:0] mot;
    logic [MW-1:0] next_mot;
    logic [1:0]    slot;
    logic [1:0]    next_slot;
    logic          busy;
    logic          next_busy;
    logic          next_out_we;
    logic          next_out_space_x;
    logic [15:0]   next_out_addr;
    logic [23:0]   next_out_data;
    logic          next_flag_we;
    logic [15:0]   next_flag_addr;
    logic          next_flag_sign;
    logic          next_servo_tick;
    logic [1:0]    n_out;
    logic          signmag;
    logic [23:0]   cv;

    always_comb begin
        next_tick_cnt   = (tick_cnt == CW'(SERVO_PERIOD - 1)) ? '0
                          : tick_cnt + 1'b1;
        next_servo_tick = tick_cnt == CW'(SERVO_PERIOD - 1);
        next_mot        = mot;
        next_slot       = slot;
        next_busy       = busy;
        next_out_we     = 1'b0;
        next_out_space_x = out_space_x;
        next_out_addr   = out_addr;
        next_out_data   = out_data;
        next_flag_we    = 1'b0;
        next_flag_addr  = flag_addr;
        next_flag_sign  = flag_sign;
        n_out   = out_count(commutation_enable[mot],
                            current_loop_setting[mot]);
        cv      = cmd_val[mot][slot];
        signmag = !variant_two && !commutation_enable[mot]
                  && command_output_address[mot][mcr_pkg::OUT_SIGNMAG_BIT];
        if (servo_tick) begin
            next_busy = 1'b1;
            next_mot  = '0;
            next_slot = 2'd0;
        end else if (busy) begin
            if (motor_activate[mot]) begin
                next_out_we      = 1'b1;
                next_out_space_x = command_output_address[mot]
                                   [mcr_pkg::OUT_SPACE_BIT];
                // Consecutive targets from the base address
                next_out_addr = command_output_address[mot][15:0]
                                + {14'h0, slot};
                next_out_data = cv;
                if (signmag) begin
                    next_out_data  = cv[23] ? 24'(-cv) : cv;
                    next_flag_we   = 1'b1;
                    next_flag_addr = flag_register_address[mot][15:0];
                    next_flag_sign = cv[23];
                end
            end
            // Ends the motor even if its count shrank mid-sequence
            if (!motor_activate[mot] || slot >= n_out - 2'd1) begin
                next_slot = 2'd0;
                if (mot == MW'(NUM_MOTORS - 1))
                    next_busy = 1'b0;
                else
                    next_mot = mot + 1'b1;
            end else
                next_slot = slot + 2'd1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt    <= '0;
            servo_tick  <= 1'b0;
            mot         <= '0;
            slot        <= 2'd0;
            busy        <= 1'b0;
            out_we      <= 1'b0;
            out_space_x <= 1'b0;
            out_addr    <= 16'h0000;
            out_data    <= 24'h000000;
            flag_we     <= 1'b0;
            flag_addr   <= 16'h0000;
            flag_sign   <= 1'b0;
        end else begin
            tick_cnt    <= next_tick_cnt;
            servo_tick  <= next_servo_tick;
            mot         <= next_mot;
            slot        <= next_slot;
            busy        <= next_busy;
            out_we      <= next_out_we;
            out_space_x <= next_out_space_x;
            out_addr    <= next_out_addr;
            out_data    <= next_out_data;
            flag_we     <= next_flag_we;
            flag_addr   <= next_flag_addr;
            flag_sign   <= next_flag_sign;
        end
    end

    // Position and write count per motor
    for (genvar g = 0; g < NUM_MOTORS; g++) begin : g_pos
        logic [23:0] next_pos;
        logic [15:0] next_wc;
        always_comb begin
            next_pos = position[g];
            next_wc  = write_count[g];
            if (servo_tick && motor_activate[g])
                next_pos = position[g] + feedback_delta;
            if (busy && mot == MW'(g) && motor_activate[g])
                next_wc = write_count[g] + 16'h0001;
        end
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                position[g]    <= 24'h000000;
                write_count[g] <= 16'h0000;
            end else begin
                position[g]    <= next_pos;
                write_count[g] <= next_wc;
            end
        end
        pos_hold_a: assert property (
            @(posedge hclk) disable iff (!hresetn)
            !motor_activate[g] |=> $stable(position[g]))
            else $error("idle motor position moved");
    end

    signmag_flag_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        flag_we |-> out_we && !$past(variant_two)) else $error("bad flag");
    one_write_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        out_we |-> $past(busy)) else $error("write outside cycle");
    single_out_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        busy && !commutation_enable[mot] |=> slot == 2'd0)
        else $error("extra output without commutation");
    two_out_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        busy && commutation_enable[mot] && current_loop_setting[mot] == 8'h00
        |=> slot != 2'd2) else $error("third output with loop off");
    idle_quiet_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        busy && !motor_activate[mot] |=> !out_we)
        else $error("write from inactive motor");
endmodule
`default_nettype wire

// ===== dv/mcr_amp_model.sv
// Amplifier-side register model that stores routed command writes
`timescale 1ns/1ps
`default_nettype none
module mcr_amp_model (
    input  wire logic        hclk,
    input  wire logic        out_we,
    input  wire logic        out_space_x,
    input  wire logic [15:0] out_addr,
    input  wire logic [23:0] out_data,
    input  wire logic        flag_we,
    input  wire logic [15:0] flag_addr,
    input  wire logic        flag_sign
);
    logic [23:0] ymem     [logic [15:0]];
    logic [23:0] xmem     [logic [15:0]];
    logic        sign_bit [logic [15:0]];

    // Separate X and Y spaces, last written value kept
    always @(posedge hclk) begin
        if (out_we && out_space_x) xmem[out_addr] = out_data;
        if (out_we && !out_space_x) ymem[out_addr] = out_data;
        if (flag_we) sign_bit[flag_addr] = flag_sign;
    end
endmodule
`default_nettype wire

// ===== dv/motor_command_output_router_test.sv
// Self-checking bench for the motor command output router
`timescale 1ns/1ps
`default_nettype none
module motor_command_output_router_test;
    localparam int NM = 4;
    localparam int SP = 64;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = '0;
    logic [2:0]  hsize = '0;
    logic [31:0] hwdata = '0;
    logic [23:0] feedback_delta = '0;
    logic        hready, hreadyout, hresp, out_we, out_space_x;
    logic        flag_we, flag_sign, servo_tick;
    logic [31:0] hrdata, rdv, s0, s1, cl;
    logic [40:0] wr_seen, exp_o;
    logic [16:0] exp_f;
    logic [15:0] exp_pos;
    logic [15:0] out_addr, flag_addr;
    logic [23:0] out_data;
    logic [40:0] q_out [$];
    logic [16:0] q_flag [$];
    logic [31:0] ctl [NM];
    logic [31:0] oad [NM];
    logic [31:0] fad [NM];
    logic [23:0] cmd [NM][3];
    logic        variant = 1'b0;
    logic        armed = 1'b0;
    int          n_fail = 0;
    int          check_count = 0;
    int          cyc = 0;

    assign hready = hreadyout;
    assign wr_seen = {out_space_x, out_addr, out_data};
    always #10 hclk = ~hclk;

    mcr_router #(.SERVO_PERIOD(SP), .NUM_MOTORS(NM)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .feedback_delta(feedback_delta), .out_we(out_we),
        .out_space_x(out_space_x), .out_addr(out_addr),
        .out_data(out_data), .flag_we(flag_we), .flag_addr(flag_addr),
        .flag_sign(flag_sign), .servo_tick(servo_tick));
    mcr_amp_model i_amp (
        .hclk(hclk), .out_we(out_we), .out_space_x(out_space_x),
        .out_addr(out_addr), .out_data(out_data), .flag_we(flag_we),
        .flag_addr(flag_addr), .flag_sign(flag_sign));

    task automatic chk(input string nm, input logic [47:0] seen,
                       input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task end_of_test;
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic logic [31:0] ra(input int m, input logic [11:0] off);
        return 32'(off) + (32'(m) << mcr_pkg::MOTOR_STRIDE_SHIFT);
    endfunction

    task automatic ahb(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'b010;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] t;
        ahb(1'b1, a, d, t);
    endtask

    task automatic rd_chk(input string nm, input logic [31:0] a, e);
        ahb(1'b0, a, 32'h0, rdv);
        chk(nm, 48'(rdv), 48'(e));
    endtask

    task automatic cfg(input int m, input logic [31:0] c, o);
        ctl[m] = c;
        oad[m] = o;
        fad[m] = 32'h1_c000 + 32'(m);
        wr(ra(m, mcr_pkg::REG_CTRL), c);
        wr(ra(m, mcr_pkg::REG_OUT_ADDR), o);
        wr(ra(m, mcr_pkg::REG_FLAG_ADDR), fad[m]);
        for (int k = 0; k < 3; k++) begin
            cmd[m][k] = 24'($urandom);
            wr(ra(m, mcr_pkg::REG_CMD) + 32'(4 * k), {8'h00, cmd[m][k]});
        end
    endtask

    // Expected writes of one servo pass, motors in order
    task automatic expect_pass;
        logic [23:0] d;
        int          n;
        for (int m = 0; m < NM; m++) begin
            n = ctl[m][1] ? (|ctl[m][9:2] ? 3 : 2) : 1;
            for (int k = 0; k < n && ctl[m][0]; k++) begin
                d = cmd[m][k];
                if (!variant && !ctl[m][1] && oad[m][16]) begin
                    d = d[23] ? -d : d;
                    q_flag.push_back({fad[m][15:0], cmd[m][0][23]});
                end
                q_out.push_back({oad[m][19], oad[m][15:0] + 16'(k), d});
            end
        end
    endtask

    task automatic sweep;
        int pend;
        int gap;
        do @(posedge hclk); while (servo_tick !== 1'b1);
        expect_pass();
        armed = 1'b1;
        gap = 0;
        do begin
            @(posedge hclk);
            gap++;
        end while (servo_tick !== 1'b1);
        chk("tick period", 48'(gap), 48'(SP));
        pend = q_out.size() + q_flag.size();
        chk("pending writes", 48'(pend), 48'h0);
        armed = 1'b0;
    endtask

    always @(posedge hclk) begin
        if (armed && out_we === 1'b1) begin
            if (q_out.size() == 0) chk("extra write", 48'h1, 48'h0);
            else begin
                exp_o = q_out.pop_front();
                chk("out wr", 48'(wr_seen), 48'(exp_o));
            end
        end
        if (armed && flag_we === 1'b1) begin
            if (q_flag.size() == 0) chk("extra flag", 48'h1, 48'h0);
            else begin
                exp_f = q_flag.pop_front();
                chk("flag wr", 48'({flag_addr, flag_sign}), 48'(exp_f));
            end
        end
    end

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 8000) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        void'($urandom(32'h2d96));
        feedback_delta <= 24'($urandom);
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("hreadyout", 48'(hreadyout), 48'h1);
        chk("hresp", 48'(hresp), 48'h0);
        chk("idle out_we", 48'(out_we), 48'h0);
        rd_chk("ctrl m0", ra(0, mcr_pkg::REG_CTRL), 32'h1);
        rd_chk("out addr m1", ra(1, mcr_pkg::REG_OUT_ADDR),
               32'(mcr_pkg::OUT_ADDR_RESET));
        rd_chk("flag addr m1", ra(1, mcr_pkg::REG_FLAG_ADDR),
               32'(mcr_pkg::FLAG_ADDR_RESET));
        wr(ra(0, 12'h01c), 32'hffff_ffff);
        rd_chk("unmapped", ra(0, 12'h01c), 32'h0);
        $display("reset and map test done");
        for (int v = 0; v < 2; v++) begin
            variant = v[0];
            wr(32'(mcr_pkg::REG_GLOBAL), 32'(v));
            rd_chk("variant", 32'(mcr_pkg::REG_GLOBAL), 32'(v));
            cfg(0, 32'h1, 32'h8_c003);
            cfg(1, 32'h3, 32'h0_c00a);
            cl = 32'($urandom_range(1, 255));
            cfg(2, 32'h3 | (cl << 2), 32'h0_c012);
            rd_chk("ctrl m2", ra(2, mcr_pkg::REG_CTRL), ctl[2]);
            rd_chk("cmd c m2", ra(2, mcr_pkg::REG_CMD_C), {8'h00, cmd[2][2]});
            cfg(3, 32'h1, 32'h1_c01a);
            sweep();
            sweep();
            $display("mode test done, variant %0d", v);
        end
        ctl[1][0] = 1'b0;
        ctl[2][0] = 1'b0;
        wr(ra(1, mcr_pkg::REG_CTRL), ctl[1]);
        wr(ra(2, mcr_pkg::REG_CTRL), ctl[2]);
        // Snapshot right after a tick, so no update slips in unseen
        do @(posedge hclk); while (servo_tick !== 1'b1);
        ahb(1'b0, ra(0, mcr_pkg::REG_STATUS), 32'h0, s0);
        ahb(1'b0, ra(1, mcr_pkg::REG_STATUS), 32'h0, s1);
        sweep();
        chk("frozen", 48'(i_amp.ymem[16'hc00a]), 48'(cmd[1][0]));
        ahb(1'b0, ra(1, mcr_pkg::REG_STATUS), 32'h0, rdv);
        chk("idle position", 48'(rdv[15:0]), 48'(s1[15:0]));
        chk("idle count", 48'(rdv[31:16]), 48'(s1[31:16]));
        ahb(1'b0, ra(0, mcr_pkg::REG_STATUS), 32'h0, rdv);
        exp_pos = s0[15:0] + 16'(feedback_delta) * 16'h2;
        chk("run position", 48'(rdv[15:0]), 48'(exp_pos));
        chk("run count", 48'(rdv[31:16]), 48'(s0[31:16] + 16'h2));
        $display("freeze test done");
        end_of_test();
    end
endmodule
`default_nettype wire
